// ### rtl/port5_gmii_rgmii_interface.sv
// Functional notes
// - the PHY-facing or MAC-facing role comes from the level of the role strap input.
// - in PHY role the partner drives tx enable, error, data and clock; the device drives col, crs, rx valid, error, data and clock.
// - in MAC role the device drives its rx outputs to the PHY and takes col, crs, valid, error, data and clock as inputs.
// - at 1000 Mbps only full duplex is used, so no collision is ever signalled there.
// - data moves as one byte per clock each way; byte-wide mode has separate valid and error on each path, reduced mode folds error into control.
// - in half duplex at 10/100 the collision output rises when a collision occurs during transmission.
// - in reduced mode the partner drives tx control, four data bits and clock; the device drives rx control, four data bits and clock.
// - the reduced interface runs up to gigabit rate with ingress and egress clock delays set in the port control register.
// - port control bit 4 enables the ingress clock delay and bit 3 the egress clock delay.
// - setting 11 delays both clocks in the device and setting 10 delays ingress only.
// - in reduced mode at gigabit rate the 125 MHz clock latches data on both edges.
// - setting 01 delays egress only, 00 delays neither, and bit 4 resets to 0 and bit 3 to 1.
// - the byte-wide interface is clocked at 125 MHz for 1000 Mbps.
`include "uplink_defines.svh"

module port5_gmii_rgmii_interface
	import uplink_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic uplink_gig_tx_clock,
	input wire logic role_select_strap,
	input wire logic reduced_mode_strap,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic core_half_duplex,
	input wire logic core_tx_valid,
	output logic core_tx_ready,
	input wire lane_s core_tx_lane,
	output logic core_rx_valid,
	output lane_s core_rx_lane,
	output logic core_collision,
	output logic core_carrier,
	input wire logic uplink_tx_enable_in,
	input wire logic uplink_tx_error_in,
	input wire logic [7:0] uplink_tx_data_in,
	output logic uplink_rx_valid_out,
	output logic uplink_rx_error_out,
	output logic [7:0] uplink_rx_data_out,
	output logic uplink_gig_rx_clock,
	input wire logic uplink_collision_i,
	output logic uplink_collision_o,
	output logic uplink_collision_oe,
	input wire logic uplink_carrier_sense_i,
	output logic uplink_carrier_sense_o,
	output logic uplink_carrier_sense_oe,
	output logic ingress_clock_delay_en,
	output logic egress_clock_delay_en
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// a toggle counts once stage two and three agree and differ from the last seen
	function automatic logic sync_event(input logic s2, input logic s3, input logic seen);
		sync_event = (s2 == s3) && (s3 != seen);
	endfunction : sync_event

	// ----------------------------------------
	// strap capture, main domain
	// ----------------------------------------
	logic [2:0] role_s_r;
	logic [2:0] mode_s_r;
	logic [2:0] settle_r;
	cap_e cap_r;
	role_e role_r;
	logic reduced_r;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			role_s_r <= 3'h0;
			mode_s_r <= 3'h0;
		end else begin
			role_s_r <= {role_s_r[1:0], role_select_strap};
			mode_s_r <= {mode_s_r[1:0], reduced_mode_strap};
		end
	end

	// straps are caught once, after the synchroniser has filled
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cap_r <= CAP_SETTLE;
			settle_r <= 3'h0;
			role_r <= ROLE_PHY;
			reduced_r <= 1'b0;
		end else begin
			unique case (cap_r)
				CAP_SETTLE: begin
					settle_r <= settle_r + 3'h1;
					if (settle_r == `STRAP_SETTLE_CYCLES && role_s_r[1] == role_s_r[2]
							&& mode_s_r[1] == mode_s_r[2]) begin
						role_r <= role_s_r[2] ? ROLE_MAC : ROLE_PHY;
						reduced_r <= mode_s_r[2];
						cap_r <= CAP_RUN;
					end
				end
				CAP_RUN: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// port control register
	// ----------------------------------------
	logic [7:0] ctrl_r;
	logic ovf_set;
	logic run;
	logic [7:0] ctrl_view;

	assign run = (cap_r == CAP_RUN);
	assign ctrl_view = {ctrl_r[7:6], (role_r == ROLE_MAC), ctrl_r[4:0]};

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= `PORT_CTRL_RESET;
		end else begin
			if (reg_wr && reg_addr == `PORT_CTRL_OFFSET) begin
				ctrl_r <= (ctrl_r & ~`PORT_CTRL_WMASK) | (reg_wdata & `PORT_CTRL_WMASK);
			end
			// overflow is write-one-to-clear, a new overflow wins
			if (ovf_set) begin
				ctrl_r[`BIT_OVERFLOW] <= 1'b1;
			end else if (reg_wr && reg_addr == `PORT_CTRL_OFFSET && reg_wdata[`BIT_OVERFLOW]) begin
				ctrl_r[`BIT_OVERFLOW] <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= (reg_addr == `PORT_CTRL_OFFSET) ? ctrl_view : 8'h00;
		end
	end

	// pad delay cells only matter in reduced mode
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ingress_clock_delay_en <= 1'b0;
			egress_clock_delay_en <= 1'b0;
		end else begin
			ingress_clock_delay_en <= reduced_r && ctrl_r[`BIT_IN_DELAY];
			egress_clock_delay_en <= reduced_r && ctrl_r[`BIT_OUT_DELAY];
		end
	end

	chk_delay_map: assert property (@(posedge mclk) disable iff (!arst_n)
		reg_wr && reg_addr == `PORT_CTRL_OFFSET && reduced_r
		|=> ##1 ingress_clock_delay_en == $past(reg_wdata[`BIT_IN_DELAY], 2)
		&& egress_clock_delay_en == $past(reg_wdata[`BIT_OUT_DELAY], 2))
		else $error("clock delay enables do not follow port control");

	chk_role_hold: assert property (@(posedge mclk) disable iff (!arst_n)
		run |=> run && $stable(role_r) && $stable(reduced_r))
		else $error("role changed after capture");

	// ----------------------------------------
	// link domain reset and level crossings
	// ----------------------------------------
	logic [1:0] lrst_r;
	logic lrst_n;
	logic [2:0] lrun_s_r;
	logic [2:0] lrole_s_r;
	logic [2:0] lred_s_r;
	logic [2:0] lgig_s_r;
	logic [2:0] lhalf_s_r;

	always_ff @(posedge uplink_gig_tx_clock or negedge arst_n) begin
		if (!arst_n) begin
			lrst_r <= 2'h0;
		end else begin
			lrst_r <= {lrst_r[0], 1'b1};
		end
	end
	assign lrst_n = lrst_r[1];

	always_ff @(posedge uplink_gig_tx_clock or negedge lrst_n) begin
		if (!lrst_n) begin
			lrun_s_r <= 3'h0;
			lrole_s_r <= 3'h0;
			lred_s_r <= 3'h0;
			lgig_s_r <= 3'h7;
			lhalf_s_r <= 3'h0;
		end else begin
			lrun_s_r <= {lrun_s_r[1:0], run};
			lrole_s_r <= {lrole_s_r[1:0], (role_r == ROLE_MAC)};
			lred_s_r <= {lred_s_r[1:0], reduced_r};
			lgig_s_r <= {lgig_s_r[1:0], ctrl_r[`BIT_SPEED_GIG]};
			lhalf_s_r <= {lhalf_s_r[1:0], core_half_duplex};
		end
	end

	// ----------------------------------------
	// ingress capture, both edges in reduced mode
	// ----------------------------------------
	logic [3:0] in_hi_r;
	logic in_ctl_hi_r;
	lane_s in_lane_r;
	logic in_valid_r;
	logic in_ready;
	logic in_push;

	// falling edge carries the upper nibble and valid xor error
	always_ff @(negedge uplink_gig_tx_clock or negedge lrst_n) begin
		if (!lrst_n) begin
			in_hi_r <= 4'h0;
			in_ctl_hi_r <= 1'b0;
		end else begin
			in_hi_r <= uplink_tx_data_in[3:0];
			in_ctl_hi_r <= uplink_tx_enable_in;
		end
	end

	logic [3:0] in_lo_r;
	logic in_ctl_lo_r;

	always_ff @(posedge uplink_gig_tx_clock or negedge lrst_n) begin
		if (!lrst_n) begin
			in_lo_r <= 4'h0;
			in_ctl_lo_r <= 1'b0;
			in_lane_r <= '0;
			in_valid_r <= 1'b0;
		end else if (lred_s_r[2]) begin
			in_lo_r <= uplink_tx_data_in[3:0];
			in_ctl_lo_r <= uplink_tx_enable_in;
			in_lane_r <= '{err: in_ctl_lo_r ^ in_ctl_hi_r, data: {in_hi_r, in_lo_r}};
			in_valid_r <= in_ctl_lo_r && lrun_s_r[2];
		end else begin
			in_lane_r <= '{err: uplink_tx_error_in, data: uplink_tx_data_in};
			in_valid_r <= uplink_tx_enable_in && lrun_s_r[2];
		end
	end

	// ----------------------------------------
	// ingress buffer and word crossing
	// ----------------------------------------
	lane_s ff_lane;
	logic ff_valid;
	logic ff_ready;
	lane_s ing_hold_r;
	logic ing_req_r;
	logic ing_busy_r;
	logic [2:0] ing_ack_s_r;
	logic ing_ack_seen_r;
	logic ovf_tgl_r;
	logic [2:0] ovf_gap_r;
	logic core_ack_r;

	// the partner cannot be stalled; a full buffer drops the byte and flags it
	assign in_push = in_valid_r && in_ready;
	assign ff_ready = !ing_busy_r;

	lane_fifo #(.WIDTH($bits(lane_s)), .DEPTH(`FIFO_DEPTH)) u_ingress_fifo (
		.clk(uplink_gig_tx_clock),
		.rst_n(lrst_n),
		.in_valid(in_valid_r),
		.in_ready(in_ready),
		.in_data(in_lane_r),
		.out_valid(ff_valid),
		.out_ready(ff_ready),
		.out_data(ff_lane)
	);

	always_ff @(posedge uplink_gig_tx_clock or negedge lrst_n) begin
		if (!lrst_n) begin
			ovf_tgl_r <= 1'b0;
			ovf_gap_r <= 3'h0;
		end else if (in_valid_r && !in_push && ovf_gap_r == 3'h0) begin
			// one toggle per burst of drops, held long enough for the slow side
			ovf_tgl_r <= !ovf_tgl_r;
			ovf_gap_r <= `OVF_HOLD_CYCLES;
		end else if (ovf_gap_r != 3'h0) begin
			ovf_gap_r <= ovf_gap_r - 3'h1;
		end
	end

	always_ff @(posedge uplink_gig_tx_clock or negedge lrst_n) begin
		if (!lrst_n) begin
			ing_ack_s_r <= 3'h0;
			ing_ack_seen_r <= 1'b0;
			ing_req_r <= 1'b0;
			ing_busy_r <= 1'b0;
			ing_hold_r <= '0;
		end else begin
			ing_ack_s_r <= {ing_ack_s_r[1:0], core_ack_r};
			if (sync_event(ing_ack_s_r[1], ing_ack_s_r[2], ing_ack_seen_r)) begin
				ing_ack_seen_r <= ing_ack_s_r[2];
				ing_busy_r <= 1'b0;
			end else if (ff_valid && !ing_busy_r) begin
				ing_hold_r <= ff_lane;
				ing_req_r <= !ing_req_r;
				ing_busy_r <= 1'b1;
			end
		end
	end

	chk_hold_stable: assert property (@(posedge uplink_gig_tx_clock) disable iff (!lrst_n)
		ing_busy_r && $past(ing_busy_r) |-> $stable(ing_hold_r) && $stable(ing_req_r))
		else $error("ingress word changed while crossing");

	// ----------------------------------------
	// main domain receive of ingress words
	// ----------------------------------------
	logic [2:0] core_req_s_r;
	logic core_req_seen_r;
	logic [2:0] ovf_s_r;
	logic ovf_seen_r;

	assign ovf_set = sync_event(ovf_s_r[1], ovf_s_r[2], ovf_seen_r);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ovf_s_r <= 3'h0;
			ovf_seen_r <= 1'b0;
		end else begin
			ovf_s_r <= {ovf_s_r[1:0], ovf_tgl_r};
			if (ovf_set) begin
				ovf_seen_r <= ovf_s_r[2];
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			core_req_s_r <= 3'h0;
			core_req_seen_r <= 1'b0;
			core_ack_r <= 1'b0;
			core_rx_valid <= 1'b0;
			core_rx_lane <= '0;
		end else begin
			core_req_s_r <= {core_req_s_r[1:0], ing_req_r};
			core_rx_valid <= 1'b0;
			if (sync_event(core_req_s_r[1], core_req_s_r[2], core_req_seen_r)) begin
				core_req_seen_r <= core_req_s_r[2];
				core_rx_lane <= ing_hold_r;
				core_rx_valid <= 1'b1;
				core_ack_r <= !core_ack_r;
			end
		end
	end

	chk_rx_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
		core_rx_valid |=> !core_rx_valid [*3])
		else $error("ingress words arrive closer than the crossing allows");

	// ----------------------------------------
	// egress word crossing, main side
	// ----------------------------------------
	lane_s eg_hold_r;
	logic eg_req_r;
	logic eg_busy_r;
	logic [2:0] eg_ack_s_r;
	logic eg_ack_seen_r;
	logic eg_ack_r;

	assign core_tx_ready = run && !eg_busy_r;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			eg_hold_r <= '0;
			eg_req_r <= 1'b0;
			eg_busy_r <= 1'b0;
			eg_ack_s_r <= 3'h0;
			eg_ack_seen_r <= 1'b0;
		end else begin
			eg_ack_s_r <= {eg_ack_s_r[1:0], eg_ack_r};
			if (sync_event(eg_ack_s_r[1], eg_ack_s_r[2], eg_ack_seen_r)) begin
				eg_ack_seen_r <= eg_ack_s_r[2];
				eg_busy_r <= 1'b0;
			end else if (core_tx_valid && core_tx_ready) begin
				eg_hold_r <= core_tx_lane;
				eg_req_r <= !eg_req_r;
				eg_busy_r <= 1'b1;
			end
		end
	end

	chk_tx_take: assert property (@(posedge mclk) disable iff (!arst_n)
		core_tx_valid && core_tx_ready |=> !core_tx_ready [*4])
		else $error("egress accepted a byte while one is in flight");

	// ----------------------------------------
	// egress drive, link side
	// ----------------------------------------
	logic [2:0] eg_req_s_r;
	logic eg_req_seen_r;
	logic eg_valid_r;
	logic eg_err_r;
	logic [7:0] eg_data_r;
	logic [3:0] eg_hi_r;
	logic eg_ctl_hi_r;

	always_ff @(posedge uplink_gig_tx_clock or negedge lrst_n) begin
		if (!lrst_n) begin
			eg_req_s_r <= 3'h0;
			eg_req_seen_r <= 1'b0;
			eg_ack_r <= 1'b0;
			eg_valid_r <= 1'b0;
			eg_err_r <= 1'b0;
			eg_data_r <= 8'h00;
		end else begin
			eg_req_s_r <= {eg_req_s_r[1:0], eg_req_r};
			eg_valid_r <= 1'b0;
			eg_err_r <= 1'b0;
			if (sync_event(eg_req_s_r[1], eg_req_s_r[2], eg_req_seen_r)) begin
				eg_req_seen_r <= eg_req_s_r[2];
				eg_valid_r <= 1'b1;
				eg_err_r <= eg_hold_r.err;
				eg_data_r <= eg_hold_r.data;
				eg_ack_r <= !eg_ack_r;
			end
		end
	end

	// falling edge launches the upper nibble and valid xor error
	always_ff @(negedge uplink_gig_tx_clock or negedge lrst_n) begin
		if (!lrst_n) begin
			eg_hi_r <= 4'h0;
			eg_ctl_hi_r <= 1'b0;
		end else begin
			eg_hi_r <= eg_data_r[7:4];
			eg_ctl_hi_r <= eg_valid_r ^ eg_err_r;
		end
	end

	// reduced mode muxes the two launched halves on the clock level
	always_comb begin
		if (lred_s_r[2]) begin
			uplink_rx_data_out = {4'h0, uplink_gig_tx_clock ? eg_data_r[3:0] : eg_hi_r};
			uplink_rx_valid_out = uplink_gig_tx_clock ? eg_valid_r : eg_ctl_hi_r;
			uplink_rx_error_out = 1'b0;
		end else begin
			uplink_rx_data_out = eg_data_r;
			uplink_rx_valid_out = eg_valid_r;
			uplink_rx_error_out = eg_err_r;
		end
	end

	// the forwarded clock; the pad delay cell adds the egress skew
	assign uplink_gig_rx_clock = uplink_gig_tx_clock;

	chk_eg_pulse: assert property (@(posedge uplink_gig_tx_clock) disable iff (!lrst_n)
		eg_valid_r |=> !eg_valid_r ##1 !eg_valid_r)
		else $error("egress byte held longer than one link clock");

	// ----------------------------------------
	// media status: collision and carrier
	// ----------------------------------------
	logic half_eff;
	logic col_r;
	logic crs_r;

	// no collisions at gigabit, full duplex only there
	assign half_eff = lhalf_s_r[2] && !lgig_s_r[2];

	always_ff @(posedge uplink_gig_tx_clock or negedge lrst_n) begin
		if (!lrst_n) begin
			col_r <= 1'b0;
			crs_r <= 1'b0;
		end else begin
			col_r <= half_eff && eg_valid_r && in_valid_r;
			crs_r <= eg_valid_r || in_valid_r;
		end
	end

	always_comb begin
		uplink_collision_o = col_r;
		uplink_carrier_sense_o = crs_r;
		uplink_collision_oe = lrun_s_r[2] && !lrole_s_r[2];
		uplink_carrier_sense_oe = lrun_s_r[2] && !lrole_s_r[2];
	end

	chk_no_gig_col: assert property (@(posedge uplink_gig_tx_clock) disable iff (!lrst_n)
		lgig_s_r[2] && $past(lgig_s_r[2]) |-> !uplink_collision_o)
		else $error("collision signalled at gigabit rate");

	chk_col_cause: assert property (@(posedge uplink_gig_tx_clock) disable iff (!lrst_n)
		half_eff && eg_valid_r && in_valid_r |=> uplink_collision_o)
		else $error("collision missed during half duplex transmit");

	chk_pin_dir: assert property (@(posedge uplink_gig_tx_clock) disable iff (!lrst_n)
		lrun_s_r[2] |-> uplink_collision_oe == !lrole_s_r[2]
		&& uplink_carrier_sense_oe == uplink_collision_oe)
		else $error("col or crs direction does not match role");

	// in MAC role the PHY drives col and crs in
	logic [2:0] col_in_s_r;
	logic [2:0] crs_in_s_r;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			col_in_s_r <= 3'h0;
			crs_in_s_r <= 3'h0;
			core_collision <= 1'b0;
			core_carrier <= 1'b0;
		end else begin
			col_in_s_r <= {col_in_s_r[1:0], uplink_collision_i};
			crs_in_s_r <= {crs_in_s_r[1:0], uplink_carrier_sense_i};
			if (col_in_s_r[1] == col_in_s_r[2]) begin
				core_collision <= col_in_s_r[2] && role_r == ROLE_MAC;
			end
			if (crs_in_s_r[1] == crs_in_s_r[2]) begin
				core_carrier <= crs_in_s_r[2] && role_r == ROLE_MAC;
			end
		end
	end

endmodule : port5_gmii_rgmii_interface

// ### rtl/uplink_defines.svh
`ifndef UPLINK_DEFINES_SVH
`define UPLINK_DEFINES_SVH

// ----------------------------------------
// port control register
// ----------------------------------------
`define PORT_CTRL_OFFSET 8'h56
`define PORT_CTRL_RESET 8'h48
`define PORT_CTRL_WMASK 8'h58
`define BIT_SPEED_GIG 6
`define BIT_ROLE_RO 5
`define BIT_IN_DELAY 4
`define BIT_OUT_DELAY 3
`define BIT_OVERFLOW 2

// ----------------------------------------
// timing
// ----------------------------------------
`define LINK_CLOCK_MHZ 125
`define MCLK_MHZ 100
`define STRAP_SETTLE_CYCLES 3'h4
`define OVF_HOLD_CYCLES 3'h7
`define FIFO_DEPTH 4

`endif

// ### rtl/uplink_pkg.sv
package uplink_pkg;

	typedef enum logic {ROLE_PHY, ROLE_MAC} role_e;

	typedef enum logic [1:0] {CAP_SETTLE, CAP_RUN} cap_e;

	// one byte of a frame with its error flag
	typedef struct packed {
		logic err;
		logic [7:0] data;
	} lane_s;

endpackage : uplink_pkg

// ### rtl/lane_fifo.sv
module lane_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic full;
	logic empty;

	assign empty = (wr_ptr_r == rd_ptr_r);
	assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem_r[rd_ptr_r[AW-1:0]];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
		end else if (in_valid && !full) begin
			wr_ptr_r <= wr_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (in_valid && !full) begin
			mem_r[wr_ptr_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr_r <= '0;
		end else if (out_ready && !empty) begin
			rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end

endmodule : lane_fifo

// ### test/uplink_partner.sv
module uplink_partner (
	output logic lclk,
	input wire logic rgmii,
	output logic tx_en,
	output logic tx_er,
	output logic [7:0] tx_d,
	input wire logic rx_dv,
	input wire logic rx_er,
	input wire logic [7:0] rx_d,
	output logic col,
	output logic crs
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [8:0] rxq[$];
	logic [4:0] rlo;

	initial begin
		lclk = 1'b0;
		tx_en = 1'b0;
		tx_er = 1'b0;
		tx_d = 8'hA5;
		col = 1'b0;
		crs = 1'b0;
		#1.3;
		forever #3 lclk = ~lclk;
	end

	// sample mid-cycle so the device's link flops have settled
	always @(negedge lclk) begin
		if (!rgmii && rx_dv === 1'b1) begin
			rxq.push_back({rx_er, rx_d});
		end
	end

	// reduced mode: low nibble mid high phase, high nibble mid low phase
	always @(posedge lclk) begin
		#1.5;
		rlo = {rx_dv, rx_d[3:0]};
		#3;
		if (rgmii && rlo[4] === 1'b1) begin
			rxq.push_back({~rx_dv, rx_d[3:0], rlo[3:0]});
		end
	end

	// ----
	// byte sender, n back to back in byte-wide mode
	// ----
	task automatic send(input logic [8:0] b, input int n);
		if (rgmii) begin
			@(negedge lclk);
			#0.5;
			tx_en = 1'b1;
			tx_d = {4'h0, b[3:0]};
			@(posedge lclk);
			#0.5;
			tx_en = ~b[8];
			tx_d = {4'h0, b[7:4]};
			@(negedge lclk);
		end else begin
			for (int i = 0; i < n; i++) begin
				@(posedge lclk);
				#0.5;
				tx_en = 1'b1;
				tx_er = b[8];
				tx_d = b[7:0] + 8'(i);
			end
			@(posedge lclk);
		end
		#0.5;
		tx_en = 1'b0;
		tx_er = 1'b0;
		// released data shows the inverse, never a stale copy
		tx_d = ~tx_d;
	endtask : send
endmodule : uplink_partner

// ### test/port5_gmii_rgmii_interface_test.sv
module port5_gmii_rgmii_interface_test
	import uplink_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic role_strap = 1'b0;
	logic red_strap = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic half_dup = 1'b0;
	logic tx_valid = 1'b0;
	lane_s tx_lane = 9'h000;
	logic col_seen = 1'b0;
	logic crs_seen = 1'b0;
	logic [7:0] reg_rdata, p_d, rx_d;
	logic tx_ready, rx_valid, core_col, core_crs, lclk, p_en, p_er, p_col, p_crs;
	logic rx_dv, rx_er, fwd_clk, col_o, col_oe, crs_o, crs_oe, ing_dly, eg_dly;
	lane_s rx_lane;
	int miscompares = 0;
	int checked = 0;
	wire col_w = col_oe ? col_o : p_col;
	wire crs_w = crs_oe ? crs_o : p_crs;

	always #5 mclk = ~mclk;
	always @(negedge lclk) begin
		if (col_o === 1'b1) col_seen = 1'b1;
		if (crs_o === 1'b1) crs_seen = 1'b1;
	end

	port5_gmii_rgmii_interface DUT (
		.mclk(mclk), .arst_n(arst_n), .uplink_gig_tx_clock(lclk),
		.role_select_strap(role_strap), .reduced_mode_strap(red_strap),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .core_half_duplex(half_dup), .core_tx_valid(tx_valid),
		.core_tx_ready(tx_ready), .core_tx_lane(tx_lane), .core_rx_valid(rx_valid),
		.core_rx_lane(rx_lane), .core_collision(core_col), .core_carrier(core_crs),
		.uplink_tx_enable_in(p_en), .uplink_tx_error_in(p_er), .uplink_tx_data_in(p_d),
		.uplink_rx_valid_out(rx_dv), .uplink_rx_error_out(rx_er), .uplink_rx_data_out(rx_d),
		.uplink_gig_rx_clock(fwd_clk), .uplink_collision_i(col_w), .uplink_collision_o(col_o),
		.uplink_collision_oe(col_oe), .uplink_carrier_sense_i(crs_w),
		.uplink_carrier_sense_o(crs_o), .uplink_carrier_sense_oe(crs_oe),
		.ingress_clock_delay_en(ing_dly), .egress_clock_delay_en(eg_dly)
	);

	uplink_partner p (
		.lclk(lclk), .rgmii(red_strap), .tx_en(p_en), .tx_er(p_er), .tx_d(p_d),
		.rx_dv(rx_dv), .rx_er(rx_er), .rx_d(rx_d), .col(p_col), .crs(p_crs)
	);

	// ----
	// shared tasks
	// ----
	task automatic end_sim;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	task automatic check(input string n, input logic [8:0] seen, input logic [8:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, exp, seen);
		end
	endtask : check

	task automatic timeout(input string n);
		miscompares++;
		$display("unexpected %s expected handshake seen timeout", n);
		end_sim();
	endtask : timeout

	task automatic reset_dut(input logic role, input logic red);
		@(negedge mclk);
		arst_n = 1'b0;
		role_strap = role;
		red_strap = red;
		repeat (8) @(negedge mclk);
		arst_n = 1'b1;
		// straps are caught some cycles after release
		repeat (12) @(negedge mclk);
	endtask : reset_dut

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask : reg_write

	task automatic reg_check(input logic [7:0] a, input logic [7:0] e, input string n);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		@(negedge mclk);
		check(n, {1'b0, reg_rdata}, {1'b0, e});
	endtask : reg_check

	task automatic core_send(input logic [8:0] b);
		int i;
		@(negedge mclk);
		tx_valid = 1'b1;
		tx_lane = b;
		for (i = 0; i < 60 && tx_ready !== 1'b1; i++) @(negedge mclk);
		if (i == 60) timeout("core_tx_ready");
		@(negedge mclk);
		tx_valid = 1'b0;
	endtask : core_send

	task automatic wait_tx(input logic [8:0] e);
		for (int i = 0; i < 80; i++) begin
			@(negedge mclk);
			if (p.rxq.size() > 0) begin
				check("egress_byte", p.rxq.pop_front(), e);
				return;
			end
		end
		timeout("egress_byte");
	endtask : wait_tx

	task automatic wait_rx(input logic [8:0] e);
		for (int i = 0; i < 80; i++) begin
			@(negedge mclk);
			if (rx_valid === 1'b1) begin
				check("ingress_byte", rx_lane, e);
				return;
			end
		end
		timeout("ingress_byte");
	endtask : wait_rx

	// ----
	// scenarios
	// ----
	task automatic t_phy_regs;
		reg_check(8'h56, 8'h48, "ctrl_reset");
		check("oe_phy", {7'h00, col_oe, crs_oe}, 9'h003);
		reg_write(8'h10, 8'hFF);
		reg_check(8'h10, 8'h00, "unmapped");
		reg_check(8'h56, 8'h48, "ctrl_after_stray");
		reg_write(8'h56, 8'hFF);
		reg_check(8'h56, 8'h58, "ctrl_write");
		check("gmii_delays", {7'h00, ing_dly, eg_dly}, 9'h000);
	endtask : t_phy_regs

	task automatic t_bytes;
		logic [8:0] v[3] = '{9'h000, 9'h0FF, 9'h15A};
		foreach (v[i]) begin
			core_send(v[i]);
			wait_tx(v[i]);
			p.send(v[i], 1);
			wait_rx(v[i]);
		end
		@(posedge lclk);
		#1;
		check("fwd_clk_high", {8'h00, fwd_clk}, 9'h001);
		@(negedge lclk);
		#1;
		check("fwd_clk_low", {8'h00, fwd_clk}, 9'h000);
	endtask : t_bytes

	task automatic t_overflow;
		p.send(9'h010, 12);
		repeat (40) @(negedge mclk);
		reg_check(8'h56, 8'h5C, "overflow_set");
		reg_write(8'h56, 8'h5C);
		reg_check(8'h56, 8'h58, "overflow_clear");
	endtask : t_overflow

	task automatic t_collision(input logic [7:0] ctrl, input logic exp);
		reg_write(8'h56, ctrl);
		half_dup = 1'b1;
		col_seen = 1'b0;
		crs_seen = 1'b0;
		fork
			p.send(9'h020, 30);
			core_send(9'h033);
		join
		repeat (40) @(negedge mclk);
		p.rxq.delete();
		check("collision", {8'h00, col_seen}, {8'h00, exp});
		check("carrier", {8'h00, crs_seen}, 9'h001);
	endtask : t_collision

	task automatic t_mac_rgmii;
		reg_check(8'h56, 8'h68, "ctrl_reset_mac");
		check("oe_mac", {7'h00, col_oe, crs_oe}, 9'h000);
		role_strap = 1'b0;
		repeat (20) @(negedge mclk);
		reg_check(8'h56, 8'h68, "role_held");
		check("oe_held", {7'h00, col_oe, crs_oe}, 9'h000);
		for (int k = 0; k < 4; k++) begin
			reg_write(8'h56, 8'h40 | 8'(k << 3));
			repeat (3) @(negedge mclk);
			check("delays", {7'h00, ing_dly, eg_dly}, 9'(k));
		end
		p.col = 1'b1;
		p.crs = 1'b1;
		repeat (8) @(negedge mclk);
		check("status_high", {7'h00, core_col, core_crs}, 9'h003);
		p.col = 1'b0;
		p.crs = 1'b0;
		repeat (8) @(negedge mclk);
		check("status_low", {7'h00, core_col, core_crs}, 9'h000);
		p.send(9'h0C3, 1);
		wait_rx(9'h0C3);
		p.send(9'h13C, 1);
		wait_rx(9'h13C);
		core_send(9'h1A5);
		wait_tx(9'h1A5);
		core_send(9'h05A);
		wait_tx(9'h05A);
	endtask : t_mac_rgmii

	initial begin
		reset_dut(1'b0, 1'b0);
		t_phy_regs();
		t_bytes();
		t_overflow();
		t_collision(8'h18, 1'b1);
		t_collision(8'h58, 1'b0);
		half_dup = 1'b0;
		reset_dut(1'b1, 1'b1);
		t_mac_rgmii();
		end_sim();
	end
endmodule : port5_gmii_rgmii_interface_test
